// ### design/scan_debug_mailbox.sv
// scan chain, debug mailbox and scan-port control registers
//
// Function
// - chain position zero is first bit shifted in and first shifted out.
// - each pin takes three cells: output data, direction, pull-up enable.
// - positions 101 to 98 enable external clock, crystal, rc, slow oscillator.
// - positions 97 to 94 observe clock input and three oscillator outputs.
// - port i/o uses 0x00-0x3F; data space adds 0x20 to each offset.
// - extended space from 0x60 is not decoded; data-space accesses stop at 0x5F.
// - cpu mailbox write passes byte to debugger and sets dirty flag.
// - mailbox read returns seven low content bits, dirty flag in bit 7.
// - shared location reaches mailbox only with fuse and debugger enable.
// - disable bit zero leaves scan port active when its fuse is programmed.
// - disable bit one turns scan port off regardless of fuse.
// - disable bit changes only on two equal writes within four cycles.
// - scan-reset flag sets on reset from the scan-reset instruction.
// - scan-reset flag clears on power-on reset or software zero.
`timescale 1ns/1ps
module scan_debug_mailbox #(
  parameter bit MAILBOX_SHARED = 1'b0
) (
  // clock and reset
  input  wire logic                         I_CLK_SYS,
  input  wire logic                         I_RESET,
  // scan pins and tap state
  input  wire logic                         I_TCK,
  input  wire logic                         I_TDI,
  input  wire logic                         I_TAP_CAPTURE_DR,
  input  wire logic                         I_TAP_SHIFT_DR,
  input  wire logic                         I_TAP_UPDATE_DR,
  output logic                              O_TDO,
  output logic                              O_TDO_OE,
  // boundary cells
  input  wire scan_debug_pkg::bscan_cells_t I_CAPTURE_CELLS,
  output scan_debug_pkg::bscan_cells_t      O_UPDATE_CELLS,
  // cpu i/o bus
  input  wire scan_debug_pkg::io_req_t      I_IO_REQ,
  output logic [7:0]                        O_IO_RDATA,
  output logic                              O_IO_HIT,
  // debugger side
  input  wire logic                         I_DBG_ACCESS_EN,
  input  wire logic                         I_DBG_CLEAR_DIRTY,
  output logic [7:0]                        O_MAILBOX_DATA,
  output logic                              O_MAILBOX_DIRTY,
  // fuses and reset sources
  input  wire logic                         I_DEBUG_ENABLE_FUSE,
  input  wire logic                         I_SCAN_PORT_FUSE,
  input  wire logic                         I_SCAN_RESET_REQ,
  output logic                              O_SCAN_PORT_ACTIVE,
  output logic                              O_SCAN_RESET_FLAG
);

  // ==========================================================================
  // synchronisers for everything arriving from the tck side or pins
  logic [scan_debug_pkg::SYNC_W-1:0] sync_s1;
  logic [scan_debug_pkg::SYNC_W-1:0] sync_s2;
  logic [scan_debug_pkg::SYNC_W-1:0] sync_s3;
  scan_debug_pkg::bscan_cells_t      cells_s1;
  scan_debug_pkg::bscan_cells_t      cells_s2;
  wire  [scan_debug_pkg::SYNC_W-1:0] sync_in;

  assign sync_in[scan_debug_pkg::SY_TCK]       = I_TCK;
  assign sync_in[scan_debug_pkg::SY_TDI]       = I_TDI;
  assign sync_in[scan_debug_pkg::SY_CAPTURE]   = I_TAP_CAPTURE_DR;
  assign sync_in[scan_debug_pkg::SY_SHIFT]     = I_TAP_SHIFT_DR;
  assign sync_in[scan_debug_pkg::SY_UPDATE]    = I_TAP_UPDATE_DR;
  assign sync_in[scan_debug_pkg::SY_DBG_CLEAR] = I_DBG_CLEAR_DIRTY;
  assign sync_in[scan_debug_pkg::SY_DBG_EN]    = I_DBG_ACCESS_EN;
  assign sync_in[scan_debug_pkg::SY_SCAN_RST]  = I_SCAN_RESET_REQ;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      sync_s1  <= '0;
      sync_s2  <= '0;
      sync_s3  <= '0;
      cells_s1 <= '0;
      cells_s2 <= '0;
    end else begin
      sync_s1  <= sync_in;
      sync_s2  <= sync_s1;
      sync_s3  <= sync_s2;
      cells_s1 <= I_CAPTURE_CELLS;
      cells_s2 <= cells_s1;
    end
  end

  // edges judged from stages two and three only
  wire tck_rise       = sync_s2[scan_debug_pkg::SY_TCK] & ~sync_s3[scan_debug_pkg::SY_TCK];
  wire tck_fall       = ~sync_s2[scan_debug_pkg::SY_TCK] & sync_s3[scan_debug_pkg::SY_TCK];
  wire dbg_clear_rise = sync_s2[scan_debug_pkg::SY_DBG_CLEAR]
                        & ~sync_s3[scan_debug_pkg::SY_DBG_CLEAR];
  wire scan_rst_rise  = sync_s2[scan_debug_pkg::SY_SCAN_RST]
                        & ~sync_s3[scan_debug_pkg::SY_SCAN_RST];
  wire dbg_access_en  = sync_s2[scan_debug_pkg::SY_DBG_EN];

  // ==========================================================================
  // address decode
  logic [15:0] io_offset_wide;
  logic        in_io_window;
  logic [5:0]  io_offset;

  // data space sits 0x20 above the port offsets
  assign io_offset_wide = I_IO_REQ.port_space ? I_IO_REQ.addr
                                              : (I_IO_REQ.addr - scan_debug_pkg::DATA_IO_BASE);
  // port accesses stop at 0x3F and data accesses at 0x5F, so extended space is not decoded
  assign in_io_window = I_IO_REQ.port_space
                        ? (I_IO_REQ.addr <= scan_debug_pkg::IO_PORT_LAST)
                        : (I_IO_REQ.addr >= scan_debug_pkg::DATA_IO_BASE
                           && I_IO_REQ.addr < scan_debug_pkg::EXT_IO_BASE);
  assign io_offset = io_offset_wide[5:0];

  wire mailbox_addr = in_io_window && (io_offset == scan_debug_pkg::DEBUG_MAILBOX_OFFSET);
  wire mcu_control_status_addr  = in_io_window
                      && (io_offset == scan_debug_pkg::MCU_CONTROL_STATUS_OFFSET);
  // shared slot belongs to the mailbox only when debug is unlocked
  wire mailbox_open = !MAILBOX_SHARED || (I_DEBUG_ENABLE_FUSE && dbg_access_en);
  wire mailbox_sel  = mailbox_addr && mailbox_open;
  wire mailbox_wr   = mailbox_sel && I_IO_REQ.wr;
  wire mcu_control_status_wr    = mcu_control_status_addr && I_IO_REQ.wr;

  // ==========================================================================
  // debug mailbox
  logic mailbox_dirty;

  // write forwards the byte to the debugger
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_MAILBOX_DATA <= scan_debug_pkg::DEBUG_MAILBOX_RESET;
    end else if (mailbox_wr) begin
      O_MAILBOX_DATA <= I_IO_REQ.wdata;
    end
  end

  // write sets dirty; set wins over a same-cycle clear
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      mailbox_dirty <= 1'b0;
    end else if (mailbox_wr) begin
      mailbox_dirty <= 1'b1;
    end else if (dbg_clear_rise) begin
      mailbox_dirty <= 1'b0;
    end
  end

  // ==========================================================================
  // scan-port disable with timed write sequence
  logic       scan_port_disable;
  logic       pend_value;
  logic [2:0] pend_count;
  wire        wr_disable_val = I_IO_REQ.wdata[scan_debug_pkg::SCAN_PORT_DISABLE_BIT];
  // second equal write inside the window commits
  wire        disable_commit = mcu_control_status_wr && (pend_count != 3'h0)
                               && (pend_value == wr_disable_val);

  // a lone write only arms the window
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      scan_port_disable <= scan_debug_pkg::MCU_CONTROL_STATUS_RESET[
                             scan_debug_pkg::SCAN_PORT_DISABLE_BIT];
      pend_value        <= 1'b0;
      pend_count        <= 3'h0;
    end else if (disable_commit) begin
      scan_port_disable <= wr_disable_val;
      pend_count        <= 3'h0;
    end else if (mcu_control_status_wr) begin
      pend_value <= wr_disable_val;
      pend_count <= scan_debug_pkg::TIMED_WINDOW_CYCLES;
    end else if (pend_count != 3'h0) begin
      pend_count <= pend_count - 3'h1;
    end
  end

  // fuse enables the port while disable is zero
  wire scan_active = I_SCAN_PORT_FUSE && !scan_port_disable;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_SCAN_PORT_ACTIVE <= 1'b0;
    end else begin
      O_SCAN_PORT_ACTIVE <= scan_active;
    end
  end

  // ==========================================================================
  // scan-reset flag and remaining control bits
  logic [7:0] mcu_misc;
  wire        wr_flag_val = I_IO_REQ.wdata[scan_debug_pkg::SCAN_RESET_FLAG_BIT];

  // scan-reset event sets, winning over a clear
  // software one leaves the flag alone
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_SCAN_RESET_FLAG <= 1'b0;
    end else if (scan_rst_rise) begin
      O_SCAN_RESET_FLAG <= 1'b1;
    end else if (mcu_control_status_wr && !wr_flag_val) begin
      O_SCAN_RESET_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      mcu_misc <= scan_debug_pkg::MCU_CONTROL_STATUS_RESET & scan_debug_pkg::MCU_MISC_MASK;
    end else if (mcu_control_status_wr) begin
      mcu_misc <= I_IO_REQ.wdata & scan_debug_pkg::MCU_MISC_MASK;
    end
  end

  // ==========================================================================
  // read mux, answered one cycle after the request
  logic [7:0] mailbox_view;
  logic [7:0] mcu_control_status_view;
  logic [7:0] next_rdata;

  // seven content bits under the dirty flag
  always_comb begin
    mailbox_view = O_MAILBOX_DATA;
    mailbox_view[scan_debug_pkg::MAILBOX_DIRTY_BIT] = mailbox_dirty;
    mcu_control_status_view = mcu_misc;
    mcu_control_status_view[scan_debug_pkg::SCAN_PORT_DISABLE_BIT] = scan_port_disable;
    mcu_control_status_view[scan_debug_pkg::SCAN_RESET_FLAG_BIT]   = O_SCAN_RESET_FLAG;
  end

  assign next_rdata = !I_IO_REQ.rd ? 8'h00
                    : mailbox_sel  ? mailbox_view
                    : mcu_control_status_addr  ? mcu_control_status_view
                    : 8'h00;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_IO_RDATA      <= 8'h00;
      O_IO_HIT        <= 1'b0;
      O_MAILBOX_DIRTY <= 1'b0;
    end else begin
      O_IO_RDATA      <= next_rdata;
      O_IO_HIT        <= (I_IO_REQ.rd || I_IO_REQ.wr) && (mailbox_sel || mcu_control_status_addr);
      O_MAILBOX_DIRTY <= mailbox_dirty;
    end
  end

  // ==========================================================================
  // boundary chain
  // pin cells packed data, control, pull-up from high to low
  // clock enable cells at the top below the reset observers
  scan_chain_shifter u_shifter (
    .i_clk           (I_CLK_SYS),
    .i_reset         (I_RESET),
    .i_active        (scan_active),
    .i_tck_rise      (tck_rise),
    .i_tck_fall      (tck_fall),
    .i_tdi           (sync_s2[scan_debug_pkg::SY_TDI]),
    .i_capture       (sync_s2[scan_debug_pkg::SY_CAPTURE]),
    .i_shift         (sync_s2[scan_debug_pkg::SY_SHIFT]),
    .i_update        (sync_s2[scan_debug_pkg::SY_UPDATE]),
    .i_capture_cells (cells_s2),
    .o_update_cells  (O_UPDATE_CELLS),
    .o_tdo           (O_TDO),
    .o_tdo_oe        (O_TDO_OE)
  );

endmodule // scan_debug_mailbox

// ### design/scan_debug_pkg.sv
// shared constants and types for the scan chain and debug mailbox block
package scan_debug_pkg;

  // ==========================================================================
  // chain geometry
  localparam int CHAIN_LEN = 104;
  localparam int PIN_COUNT = 31;
  localparam int POS_EXT_CLK_ENABLE   = 101;
  localparam int POS_SLOW_OSC_ENABLE  = 98;
  localparam int POS_EXT_CLK_OBSERVE  = 97;
  localparam int POS_SLOW_CLK_OBSERVE = 94;

  // ==========================================================================
  // i/o address map
  localparam logic [15:0] IO_PORT_LAST   = 16'h003F;
  localparam logic [15:0] DATA_IO_BASE   = 16'h0020;
  localparam logic [15:0] EXT_IO_BASE    = 16'h0060;
  localparam logic [5:0]  DEBUG_MAILBOX_OFFSET      = 6'h22;
  localparam logic [5:0]  MCU_CONTROL_STATUS_OFFSET = 6'h34;

  // ==========================================================================
  // register fields and reset values
  localparam logic [7:0] DEBUG_MAILBOX_RESET      = 8'h20;
  localparam logic [7:0] MCU_CONTROL_STATUS_RESET = 8'h20;
  localparam logic [7:0] MCU_MISC_MASK            = 8'h6F;
  localparam int MAILBOX_DIRTY_BIT     = 7;
  localparam int SCAN_PORT_DISABLE_BIT = 7;
  localparam int SCAN_RESET_FLAG_BIT   = 4;
  localparam logic [2:0] TIMED_WINDOW_CYCLES = 3'h4;

  // ==========================================================================
  // indices into the synchroniser vector
  localparam int SYNC_W       = 8;
  localparam int SY_TCK       = 0;
  localparam int SY_TDI       = 1;
  localparam int SY_CAPTURE   = 2;
  localparam int SY_SHIFT     = 3;
  localparam int SY_UPDATE    = 4;
  localparam int SY_DBG_CLEAR = 5;
  localparam int SY_DBG_EN    = 6;
  localparam int SY_SCAN_RST  = 7;

  // ==========================================================================
  // types
  typedef struct packed {
    logic data;
    logic control;
    logic pullup_enable;
  } pin_cell_t;

  // first field sits at the top of the chain, pins[0] at position 0
  typedef struct packed {
    logic      reset_observe_cell;
    logic      high_voltage_reset_observe;
    logic      external_clock_enable_cell;
    logic      crystal_osc_enable_cell;
    logic      rc_osc_enable_cell;
    logic      slow_osc_enable_cell;
    logic      external_clock_observe;
    logic      crystal_clock_observe;
    logic      rc_clock_observe;
    logic      slow_clock_observe;
    logic      two_wire_enable_cell;
    pin_cell_t [PIN_COUNT-1:0] pins;
  } bscan_cells_t;

  typedef struct packed {
    logic        port_space;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } io_req_t;

endpackage

// ### design/scan_chain_shifter.sv
// boundary-scan shift, capture and update register
`timescale 1ns/1ps
module scan_chain_shifter (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  // tap edges and state, already synchronised
  input  wire logic                         i_active,
  input  wire logic                         i_tck_rise,
  input  wire logic                         i_tck_fall,
  input  wire logic                         i_tdi,
  input  wire logic                         i_capture,
  input  wire logic                         i_shift,
  input  wire logic                         i_update,
  // parallel cells
  input  wire scan_debug_pkg::bscan_cells_t i_capture_cells,
  output scan_debug_pkg::bscan_cells_t      o_update_cells,
  // serial out
  output logic                              o_tdo,
  output logic                              o_tdo_oe
);

  // ==========================================================================
  // shift register
  scan_debug_pkg::bscan_cells_t shift_reg;
  scan_debug_pkg::bscan_cells_t next_update;
  logic [scan_debug_pkg::CHAIN_LEN-1:0] shifted;

  // enters at top, bit 0 leaves first
  assign shifted = {i_tdi, shift_reg[scan_debug_pkg::CHAIN_LEN-1:1]};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shift_reg <= '0;
    end else if (i_active && i_tck_rise && i_capture) begin
      shift_reg <= i_capture_cells;
    end else if (i_active && i_tck_rise && i_shift) begin
      shift_reg <= shifted;
    end
  end

  // ==========================================================================
  // update latch
  // observe-only cells drive nothing
  always_comb begin
    next_update = shift_reg;
    next_update.reset_observe_cell         = 1'b0;
    next_update.high_voltage_reset_observe = 1'b0;
    next_update.external_clock_observe     = 1'b0;
    next_update.crystal_clock_observe      = 1'b0;
    next_update.rc_clock_observe           = 1'b0;
    next_update.slow_clock_observe         = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_update_cells <= '0;
    end else if (i_active && i_tck_fall && i_update) begin
      o_update_cells <= next_update;
    end
  end

  // ==========================================================================
  // serial output, changes on falling tck
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      if (i_tck_fall) begin
        o_tdo <= shift_reg[0];
      end
      // driven only while shifting; idle pin floats to save current
      o_tdo_oe <= i_active && i_shift;
    end
  end

endmodule // scan_chain_shifter

// ### verif/scan_debug_mailbox_sva.sv
// concurrent checks on the scan debug mailbox ports
`timescale 1ns/1ps
module scan_debug_mailbox_sva (
  // clock and reset
  input wire logic                         I_CLK_SYS,
  input wire logic                         I_RESET,
  // inputs watched
  input wire scan_debug_pkg::io_req_t      I_IO_REQ,
  input wire logic                         I_SCAN_PORT_FUSE,
  input wire logic                         I_SCAN_RESET_REQ,
  // outputs watched
  input wire logic [7:0]                   O_IO_RDATA,
  input wire logic                         O_IO_HIT,
  input wire logic [7:0]                   O_MAILBOX_DATA,
  input wire logic                         O_MAILBOX_DIRTY,
  input wire logic                         O_TDO_OE,
  input wire logic                         O_SCAN_PORT_ACTIVE,
  input wire logic                         O_SCAN_RESET_FLAG,
  input wire scan_debug_pkg::bscan_cells_t O_UPDATE_CELLS
);
  // ==============================
  // decode helpers
  wire logic wr_cs = I_IO_REQ.wr & (I_IO_REQ.port_space ? I_IO_REQ.addr == 16'h0034
                                                        : I_IO_REQ.addr == 16'h0054);
  wire logic obs   = O_UPDATE_CELLS.reset_observe_cell | O_UPDATE_CELLS.high_voltage_reset_observe
                   | O_UPDATE_CELLS.external_clock_observe | O_UPDATE_CELLS.crystal_clock_observe
                   | O_UPDATE_CELLS.rc_clock_observe | O_UPDATE_CELLS.slow_clock_observe;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  // ==============================
  // properties
  property p_ext_refused;
    (I_IO_REQ.rd | I_IO_REQ.wr) && I_IO_REQ.port_space && I_IO_REQ.addr > 16'h003F |=> !O_IO_HIT;
  endproperty
  a_ext_refused: assert property (p_ext_refused) else $error("port access above range hit");
  property p_mb_write;
    I_IO_REQ.wr && !I_IO_REQ.port_space && I_IO_REQ.addr == 16'h0042
      |=> O_MAILBOX_DATA == $past(I_IO_REQ.wdata) ##1 O_MAILBOX_DIRTY;
  endproperty
  a_mb_write: assert property (p_mb_write) else $error("mailbox write not passed");
  property p_mb_read;
    I_IO_REQ.rd && I_IO_REQ.port_space && I_IO_REQ.addr == 16'h0022
      |=> O_IO_HIT && O_IO_RDATA[7] == O_MAILBOX_DIRTY
          && ((O_IO_RDATA ^ $past(O_MAILBOX_DATA)) & 8'h7F) == 8'h00;
  endproperty
  a_mb_read: assert property (p_mb_read) else $error("mailbox read data wrong");
  property p_port_fuse;
    !I_SCAN_PORT_FUSE |=> !O_SCAN_PORT_ACTIVE;
  endproperty
  a_port_fuse: assert property (p_port_fuse) else $error("port active without fuse");
  property p_oe_off;
    (!O_SCAN_PORT_ACTIVE) [*3] |-> !O_TDO_OE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("tdo driven while port off");
  property p_timed;
    $changed(O_SCAN_PORT_ACTIVE) && !$past(I_RESET) && !$past(I_RESET, 2)
      && $past(I_SCAN_PORT_FUSE) == $past(I_SCAN_PORT_FUSE, 2) |-> $past(wr_cs, 2);
  endproperty
  a_timed: assert property (p_timed) else $error("port state changed without write");
  property p_flag_set;
    $rose(I_SCAN_RESET_REQ) |-> ##[1:5] O_SCAN_RESET_FLAG;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("scan reset flag not set");
  property p_flag_clear;
    (!I_SCAN_RESET_REQ) [*6] ##0 (wr_cs && !I_IO_REQ.wdata[4]) |=> !O_SCAN_RESET_FLAG;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("scan reset flag not cleared");
  property p_flag_keep;
    wr_cs && I_IO_REQ.wdata[4] && O_SCAN_RESET_FLAG |=> O_SCAN_RESET_FLAG;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("writing one cleared flag");
  property p_reset_vals;
    $fell(I_RESET) |-> O_MAILBOX_DATA == 8'h20 && !O_MAILBOX_DIRTY && !O_SCAN_RESET_FLAG;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong values after reset");
  property p_observe_zero;
    !obs;
  endproperty
  a_observe_zero: assert property (p_observe_zero) else $error("observe cell updated");
endmodule // scan_debug_mailbox_sva

bind scan_debug_mailbox scan_debug_mailbox_sva chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_IO_REQ(I_IO_REQ),
  .I_SCAN_PORT_FUSE(I_SCAN_PORT_FUSE), .I_SCAN_RESET_REQ(I_SCAN_RESET_REQ),
  .O_IO_RDATA(O_IO_RDATA), .O_IO_HIT(O_IO_HIT), .O_MAILBOX_DATA(O_MAILBOX_DATA),
  .O_MAILBOX_DIRTY(O_MAILBOX_DIRTY), .O_TDO_OE(O_TDO_OE),
  .O_SCAN_PORT_ACTIVE(O_SCAN_PORT_ACTIVE), .O_SCAN_RESET_FLAG(O_SCAN_RESET_FLAG),
  .O_UPDATE_CELLS(O_UPDATE_CELLS));

// ### verif/scan_tester_model.sv
// jtag tester and debugger model on the far side of the scan port
`timescale 1ns/1ps
module scan_tester_model (
  // clock
  input  wire logic i_clk,
  // scan port
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tdi,
  output logic      o_capture,
  output logic      o_shift,
  output logic      o_update,
  // debugger side
  output logic      o_dbg_clear
);
  initial begin
    {o_tck, o_tdi, o_capture, o_shift, o_update, o_dbg_clear} = 6'h00;
  end
  // ==============================
  // link timing, 160 ns period, clock parked low between frames
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  // ==============================
  // one frame: capture, 104 shifts, update
  task automatic frame(input logic [103:0] pat, output logic [103:0] seen);
    o_capture = 1'h1;
    half();
    o_tck = 1'h1;
    half();
    o_tck = 1'h0;
    o_capture = 1'h0;
    o_shift = 1'h1;
    // bit zero first, no reserved cells here
    for (int i = 0; i < 104; i++) begin
      o_tdi = pat[i];
      half();
      o_tck = 1'h1;
      repeat (2) @(negedge i_clk);
      seen[i] = i_tdo;
      repeat (2) @(negedge i_clk);
      o_tck = 1'h0;
    end
    o_shift = 1'h0;
    // released line shows the inverse, not a stale bit
    o_tdi = ~o_tdi;
    half();
    o_update = 1'h1;
    half();
    o_tck = 1'h1;
    half();
    o_tck = 1'h0;
    half();
    o_update = 1'h0;
  endtask
  task automatic clear_dirty();
    o_dbg_clear = 1'h1;
    half();
    o_dbg_clear = 1'h0;
    half();
  endtask
endmodule // scan_tester_model

// ### verif/scan_chain_debug_mailbox_tb.sv
// self-checking bench for the scan chain and debug mailbox block
`timescale 1ns/1ps
module scan_chain_debug_mailbox_tb;
  // ==============================
  // signals
  localparam logic [103:0] OBS = {2'h3, 4'h0, 4'hF, 94'h0};
  logic                         clk, rst, tck, tdi, cap_lv, shf_lv, upd_lv, tdo, tdo_oe;
  logic                         hit, dirty, dbg_clr, active, flag, fuse, sreq;
  logic                         pend = 1'h0;
  logic [7:0]                   rdata, mb_data, b, d;
  logic [8:0]                   n;
  logic [103:0]                 pat, seen, capv;
  logic [17:0]                  bad [4] = '{18'h20062, 18'h20042, 18'h00022, 18'h10060};
  logic [8:0]                   notes [$];
  scan_debug_pkg::bscan_cells_t cells, upd;
  scan_debug_pkg::io_req_t      req;
  int                           fails = 0;
  int                           n_compared = 0;

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  scan_debug_mailbox uut (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_TCK(tck), .I_TDI(tdi), .I_TAP_CAPTURE_DR(cap_lv),
    .I_TAP_SHIFT_DR(shf_lv), .I_TAP_UPDATE_DR(upd_lv), .O_TDO(tdo), .O_TDO_OE(tdo_oe),
    .I_CAPTURE_CELLS(cells), .O_UPDATE_CELLS(upd), .I_IO_REQ(req), .O_IO_RDATA(rdata),
    .O_IO_HIT(hit), .I_DBG_ACCESS_EN(1'h1), .I_DBG_CLEAR_DIRTY(dbg_clr),
    .O_MAILBOX_DATA(mb_data), .O_MAILBOX_DIRTY(dirty), .I_DEBUG_ENABLE_FUSE(1'h1),
    .I_SCAN_PORT_FUSE(fuse), .I_SCAN_RESET_REQ(sreq), .O_SCAN_PORT_ACTIVE(active),
    .O_SCAN_RESET_FLAG(flag));
  scan_tester_model tester (
    .i_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tdi(tdi), .o_capture(cap_lv),
    .o_shift(shf_lv), .o_update(upd_lv), .o_dbg_clear(dbg_clr));
  // ==============================
  // tasks
  task automatic check(input string what, input logic [103:0] s, input logic [103:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask
  // m is {port_space, wr}; e is the expected {hit, rdata}
  task automatic io(input logic [1:0] m, input logic [15:0] a, input logic [7:0] wd,
                    input logic [8:0] e);
    @(negedge clk);
    req = '{m[1], m[0], !m[0], a, wd};
    notes.push_back(e);
  endtask
  task automatic idle(input int k);
    @(negedge clk);
    req = '0;
    repeat (k - 1) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // answer lands one cycle after the request edge
  // judge the request standing at this edge by what the edge itself launched
  initial forever begin
    @(posedge clk);
    pend = req.rd | req.wr;
    #1;
    if (pend) begin
      n = notes.pop_front();
      check("io_answer", {hit, rdata}, n);
    end
  end
  initial begin
    #400000;
    fails++;
    $display("unexpected watchdog: expected finish seen hang");
    give_verdict();
  end
  // ==============================
  // tests
  initial begin
    rst = 1'h1;
    req = '0;
    cells = '0;
    fuse = 1'h1;
    sreq = 1'h0;
    void'($urandom(32'hA973CBFB));
    repeat (8) @(negedge clk);
    rst = 1'h0;
    idle(2);
    check("mailbox_data", mb_data, 8'h20);
    check("scan_active", active, 1'h1);
    io(2'h2, 16'h0022, 8'h00, 9'h120);
    io(2'h0, 16'h0054, 8'h00, 9'h120);
    foreach (bad[i]) io(bad[i][17:16], bad[i][15:0], 8'hFF, 9'h000);
    b = 8'($urandom);
    io(2'h1, 16'h0042, b, 9'h100);
    io(2'h2, 16'h0022, 8'h00, {2'h3, b[6:0]});
    idle(2);
    check("mailbox_data", mb_data, b);
    check("mailbox_dirty", dirty, 1'h1);
    tester.clear_dirty();
    io(2'h2, 16'h0022, 8'h00, {2'h2, b[6:0]});
    capv = 104'({$urandom, $urandom, $urandom, $urandom});
    pat = 104'({$urandom, $urandom, $urandom, $urandom});
    cells = capv;
    idle(4);
    tester.frame(pat, seen);
    idle(8);
    check("tdo_stream", seen, capv);
    check("update_cells", upd, pat & ~OBS);
    check("ext_clk_enable", upd.external_clock_enable_cell, pat[101]);
    check("slow_osc_enable", upd.slow_osc_enable_cell, pat[98]);
    check("pin_top_data", upd.pins[30].data, pat[92]);
    check("pin0_pullup", upd.pins[0].pullup_enable, pat[0]);
    check("crystal_observe", seen[96], cells.crystal_clock_observe);
    io(2'h3, 16'h0034, 8'h80, 9'h100);
    idle(4);
    io(2'h3, 16'h0034, 8'h80, 9'h100);
    idle(7);
    check("scan_active", active, 1'h1);
    io(2'h3, 16'h0034, 8'h80, 9'h100);
    idle(3);
    io(2'h3, 16'h0034, 8'h80, 9'h100);
    idle(3);
    check("scan_active", active, 1'h0);
    check("tdo_oe", tdo_oe, 1'h0);
    io(2'h0, 16'h0054, 8'h00, 9'h180);
    // drop the read strobe before the long frame
    idle(1);
    tester.frame(~pat, seen);
    check("update_hold", upd, pat & ~OBS);
    io(2'h3, 16'h0034, 8'h00, 9'h100);
    io(2'h3, 16'h0034, 8'h00, 9'h100);
    idle(3);
    check("scan_active", active, 1'h1);
    fuse = 1'h0;
    idle(3);
    check("scan_active", active, 1'h0);
    fuse = 1'h1;
    sreq = 1'h1;
    idle(6);
    check("scan_reset_flag", flag, 1'h1);
    io(2'h3, 16'h0034, 8'h10, 9'h100);
    io(2'h2, 16'h0034, 8'h00, 9'h110);
    sreq = 1'h0;
    d = 8'($urandom) & 8'h6F;
    idle(7);
    io(2'h1, 16'h0054, d, 9'h100);
    io(2'h0, 16'h0054, 8'h00, {1'h1, d});
    io(2'h1, 16'h0042, 8'h5A, 9'h100);
    sreq = 1'h1;
    idle(6);
    sreq = 1'h0;
    rst = 1'h1;
    idle(3);
    rst = 1'h0;
    idle(2);
    check("scan_reset_flag", flag, 1'h0);
    check("mailbox_dirty", dirty, 1'h0);
    check("mailbox_data", mb_data, 8'h20);
    give_verdict();
  end
endmodule // scan_chain_debug_mailbox_tb
